// ===== hdl/downstream_window_base_regs.v
/*
  base address registers of two downstream forwarding windows, their
  axi4-lite register slave, and the downstream claim and translation.
  assumes the setup and translated-base registers live elsewhere and are
  loaded there at initialization; their values arrive as plain inputs.
*/
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "window_defs_regs.vh"

module downstream_window_base_regs (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // axi4-lite write address and data
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  // axi4-lite write response
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // setup and translated-base values from outside
  input wire [31:0] win1_setup,
  input wire [31:0] win2_setup,
  input wire [31:0] win1_xlat_base,
  input wire [31:0] win2_xlat_base,
  // downstream access to decode
  input wire [31:0] ds_addr,
  input wire ds_is_io,
  // claim and translated address
  output reg win1_claim,
  output reg win2_claim,
  output reg [31:0] xlat_addr
);

  // ==========================================================
  // helpers

  // window enabled only when setup bit 31 set and setup nonzero
  function win_enabled;
    input [31:0] setup;
    begin
      win_enabled = setup[`SETUP_ENABLE_BIT] && (setup != 32'h0000_0000);
    end
  endfunction

  // address bits compared for a hit: memory 4kb..2gb, io 64b..256b
  function [31:0] win_mask;
    input [31:0] setup;
    input io;
    begin
      win_mask = 32'h0000_0000;
      if (io) begin
        win_mask[31:8] = 24'hff_ffff;
        win_mask[`IO_SIZE_MSB:`IO_SIZE_LSB] = setup[`IO_SIZE_MSB:`IO_SIZE_LSB];
      end else begin
        win_mask[`BASE_MSB:`BASE_LSB] = setup[`BASE_MSB:`BASE_LSB];
        win_mask[31] = 1'b1;
      end
    end
  endfunction

  // byte-lane merge of write data
  function [31:0] strobe_merge;
    input [31:0] old;
    input [31:0] data;
    input [3:0] strb;
    integer i;
    begin
      strobe_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          strobe_merge[i*8 +: 8] = data[i*8 +: 8];
        end
      end
    end
  endfunction

  // writable bits take the new data, read-only bits keep their value
  function [19:0] masked_update;
    input [19:0] old;
    input [19:0] data;
    input [19:0] wmask;
    begin
      masked_update = (old & ~wmask) | (data & wmask);
    end
  endfunction

  // window bits from the translated base, the rest from the access
  function [31:0] translate;
    input [31:0] xbase;
    input [31:0] addr;
    input [31:0] amask;
    begin
      translate = (xbase & amask) | (addr & ~amask);
    end
  endfunction

  // word-aligned register offset of a bus address
  function [7:0] word_offset;
    input [7:0] addr;
    begin
      word_offset = {addr[7:2], 2'b00};
    end
  endfunction

  // ==========================================================
  // window attributes and visible register words

  reg [19:0] win1_base_reg;
  reg [19:0] win2_base_reg;
  wire win1_en;
  wire win2_en;
  wire win1_io;
  wire [1:0] win1_type;
  wire [19:0] win1_wmask;
  wire [19:0] win2_wmask;
  wire [31:0] win1_word;
  wire [31:0] win2_word;

  assign win1_en = win_enabled(win1_setup);
  assign win2_en = win_enabled(win2_setup);
  assign win1_io = win1_setup[`SPACE_BIT];
  // reserved codes fold to 32-bit decode
  assign win1_type = win1_setup[`TYPE_MSB] ? `TYPE_32BIT
                   : win1_setup[`TYPE_MSB:`TYPE_LSB];
  assign win1_wmask = win1_en ? win1_setup[`BASE_MSB:`BASE_LSB] : 20'h0_0000;
  assign win2_wmask = win2_en ? win2_setup[`BASE_MSB:`BASE_LSB] : 20'h0_0000;

  assign win1_word = {win1_base_reg & win1_wmask, 8'h00,
                      win1_setup[`PREFETCH_BIT], win1_type, win1_io};
  assign win2_word = {win2_base_reg & win2_wmask, 8'h00,
                      win2_setup[`PREFETCH_BIT], `TYPE_32BIT, 1'b0};

  // ==========================================================
  // write channel

  reg aw_held_reg;
  reg w_held_reg;
  reg [7:0] awaddr_reg;
  reg [31:0] wdata_reg;
  reg [3:0] wstrb_reg;
  wire aw_take;
  wire w_take;
  wire do_write;
  wire [31:0] win1_merged;
  wire [31:0] win2_merged;

  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign do_write = aw_held_reg && w_held_reg && !s_axi_bvalid;
  assign win1_merged = strobe_merge(win1_word, wdata_reg, wstrb_reg);
  assign win2_merged = strobe_merge(win2_word, wdata_reg, wstrb_reg);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
      win1_base_reg <= `BASE_RESET;
      win2_base_reg <= `BASE_RESET;
    end else begin
      if (!aw_held_reg && !s_axi_bvalid && !aw_take) begin
        s_axi_awready <= 1'b1;
      end
      if (!w_held_reg && !s_axi_bvalid && !w_take) begin
        s_axi_wready <= 1'b1;
      end
      if (aw_take) begin
        aw_held_reg <= 1'b1;
        awaddr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_held_reg <= 1'b1;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `RESP_OKAY;
        case (word_offset(awaddr_reg))
          `WIN1_BASE_OFFSET: begin
            win1_base_reg <= masked_update(win1_base_reg, win1_merged[`BASE_MSB:`BASE_LSB],
                                           win1_wmask);
          end
          `WIN2_BASE_OFFSET: begin
            win2_base_reg <= masked_update(win2_base_reg, win2_merged[`BASE_MSB:`BASE_LSB],
                                           win2_wmask);
          end
          default: begin
            s_axi_bresp <= `RESP_SLVERR;
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================
  // read channel

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        case (word_offset(s_axi_araddr))
          `WIN1_BASE_OFFSET: begin
            s_axi_rdata <= win1_word;
            s_axi_rresp <= `RESP_OKAY;
          end
          `WIN2_BASE_OFFSET: begin
            s_axi_rdata <= win2_word;
            s_axi_rresp <= `RESP_OKAY;
          end
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end else if (!s_axi_rvalid) begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ==========================================================
  // downstream claim and direct translation

  wire [31:0] win1_amask;
  wire [31:0] win2_amask;
  wire [31:0] win1_base_addr;
  wire [31:0] win2_base_addr;
  wire win1_hit;
  wire win2_hit;

  assign win1_amask = win_mask(win1_setup, win1_io);
  assign win2_amask = win_mask(win2_setup, 1'b0);
  assign win1_base_addr = {win1_base_reg & win1_wmask, 12'h000};
  assign win2_base_addr = {win2_base_reg & win2_wmask, 12'h000};
  assign win1_hit = win1_en && (ds_is_io == win1_io)
                 && ((ds_addr & win1_amask) == (win1_base_addr & win1_amask));
  assign win2_hit = win2_en && !ds_is_io
                 && ((ds_addr & win2_amask) == (win2_base_addr & win2_amask));

  always @(posedge aclk) begin
    if (!aresetn) begin
      win1_claim <= 1'b0;
      win2_claim <= 1'b0;
      xlat_addr <= 32'h0000_0000;
    end else begin
      win1_claim <= win1_hit;
      win2_claim <= win2_hit && !win1_hit;
      if (win1_hit) begin
        xlat_addr <= translate(win1_xlat_base, ds_addr, win1_amask);
      end else if (win2_hit) begin
        xlat_addr <= translate(win2_xlat_base, ds_addr, win2_amask);
      end else begin
        xlat_addr <= ds_addr;
      end
    end
  end

endmodule

// ===== hdl/window_defs_regs.vh
/*
  offsets, field positions, reset values and codes for the downstream
  window base address registers.
  assumes inclusion by bare name from the design file.
*/
`ifndef WINDOW_DEFS_REGS_VH
`define WINDOW_DEFS_REGS_VH

// ==========================================================
// register byte offsets
`define WIN1_BASE_OFFSET 8'h18
`define WIN2_BASE_OFFSET 8'h1c
// setup and translated-base offsets held outside this block
`define WIN1_SETUP_OFFSET 12'h0ac
`define WIN2_SETUP_OFFSET 12'h00c
`define WIN1_XLAT_OFFSET 12'h0a8
`define WIN2_XLAT_OFFSET 12'h008

// ==========================================================
// field positions
`define SPACE_BIT 0
`define TYPE_LSB 1
`define TYPE_MSB 2
`define PREFETCH_BIT 3
`define BASE_LSB 12
`define BASE_MSB 31
`define SETUP_ENABLE_BIT 31
`define IO_SIZE_LSB 6
`define IO_SIZE_MSB 7

// ==========================================================
// reset values and codes
`define BASE_RESET 20'h0_0000
`define TYPE_32BIT 2'h0
`define TYPE_64BIT 2'h1
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== testbench/test_downstream_window_base_regs.sv
/* bench for the downstream window base registers
   drives the register bus and decode inputs itself */
`timescale 1ns/1ps
`include "window_defs_regs.vh"
module test_downstream_window_base_regs;
  reg aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ds_is_io, dchk;
  reg [7:0] awaddr, araddr;
  reg [3:0] wstrb;
  reg [31:0] wdata, s1, s2, x1, x2, ds_addr, seed, d;
  wire awready, wready, bvalid, arready, rvalid, c1, c2;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata, xa;
  logic [33:0] q[$];
  int fail_count, n_tests, i, n;

  downstream_window_base_regs u_downstream_window_base_regs (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .win1_setup(s1), .win2_setup(s2), .win1_xlat_base(x1), .win2_xlat_base(x2),
    .ds_addr(ds_addr), .ds_is_io(ds_is_io),
    .win1_claim(c1), .win2_claim(c2), .xlat_addr(xa));

  // ==========
  // helpers
  function [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    rnd = seed;
  endfunction
  task check(input string nm, input [33:0] s, input [33:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask
  task conclude;
    if (fail_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task wait_ok(input logic ok);
    if (!ok) begin
      fail_count++;
      conclude;
    end
  endtask
  task wr(input [7:0] a, input [31:0] v, input [3:0] s, input [1:0] r);
    logic got;
    got = 0;
    q.push_back({r, 32'h0000_0000});
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (i = 0; i < 20 && !got; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      got = (bvalid === 1'b1);
    end
    wait_ok(got);
    bready <= 0;
    @(posedge aclk);
  endtask
  task rd(input [7:0] a, input [33:0] e);
    logic got;
    got = 0;
    q.push_back(e);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    for (i = 0; i < 20 && !got; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      got = (rvalid === 1'b1);
    end
    wait_ok(got);
    rready <= 0;
    @(posedge aclk);
  endtask
  task dec(input [31:0] a, input io, input [33:0] e);
    q.push_back(e);
    ds_addr <= a;
    ds_is_io <= io;
    @(posedge aclk);
    dchk <= 1;
    @(posedge aclk);
    dchk <= 0;
  endtask

  // ==========
  // result watcher
  always @(posedge aclk) begin
    if (bvalid && bready) check("bresp", {bresp, 32'h0000_0000}, q.pop_front());
    if (rvalid && rready) check("read", {rresp, rdata}, q.pop_front());
    if (dchk) check("decode", {c1, c2, xa}, q.pop_front());
  end

  initial begin
    aclk = 0;
    forever #10 aclk = ~aclk;
  end

  initial begin
    seed = 32'h2315_fb3a;
    {aresetn, awaddr, araddr, awvalid, wvalid, bready, arvalid, rready, dchk} = 0;
    {wdata, wstrb, s1, s2, x1, x2, ds_addr, ds_is_io} = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(`WIN1_BASE_OFFSET, 0);
    rd(`WIN2_BASE_OFFSET, 0);
    s1 <= 32'hfff0_0ffa;
    s2 <= 32'hffff_f00e;
    x1 <= 32'habc0_0000;
    x2 <= rnd();
    d = rnd();
    wr(`WIN1_BASE_OFFSET, d, 4'hf, `RESP_OKAY);
    wr(`WIN1_BASE_OFFSET, 32'h5634_5678, 4'h8, `RESP_OKAY);
    rd(`WIN1_BASE_OFFSET, {10'h056, d[23:20], 20'h0_000a});
    dec({8'h56, d[23:20], 20'h4_5678}, 1'b0, {2'b10, 32'habc4_5678});
    d = rnd();
    // top bit set keeps window 2 clear of window 1
    d[31] = 1'b1;
    wr(`WIN2_BASE_OFFSET, d, 4'hf, `RESP_OKAY);
    rd(`WIN2_BASE_OFFSET, {2'b00, d[31:12], 12'h008});
    dec({d[31:12], 12'h345}, 1'b0, {2'b01, x2[31:12], 12'h345});
    dec({d[31:12], 12'h345}, 1'b1, {2'b00, d[31:12], 12'h345});
    s2 <= 32'h7fff_f008;
    rd(`WIN2_BASE_OFFSET, 34'h0_0000_0008);
    dec({d[31:12], 12'h345}, 1'b0, {2'b00, d[31:12], 12'h345});
    s2 <= 0;
    wr(`WIN2_BASE_OFFSET, rnd(), 4'hf, `RESP_OKAY);
    rd(`WIN2_BASE_OFFSET, 0);
    wr(8'h20, rnd(), 4'hf, `RESP_SLVERR);
    rd(8'h20, {`RESP_SLVERR, 32'h0000_0000});
    // window 1 as a 64-byte io window at zero, reserved type code folded
    s1 <= 32'h8000_00c7;
    x1 <= 32'h1234_56c0;
    rd(`WIN1_BASE_OFFSET, 34'h0_0000_0001);
    dec(32'h0000_0025, 1'b1, {2'b10, 32'h1234_56e5});
    dec(32'h0000_0065, 1'b1, {2'b00, 32'h0000_0065});
    dec(32'h0000_0025, 1'b0, {2'b00, 32'h0000_0025});
    s1 <= 32'h8000_0007;
    dec(32'h0000_00a5, 1'b1, {2'b10, 32'h1234_56a5});
    for (n = 0; n < 300; n++) begin
      d = rnd();
      s1 <= d[0] ? 32'h8000_00c1 : 32'hfff0_0ffa;
      s2 <= {d[1], 31'h7fff_f000};
      ds_is_io <= d[2];
      ds_addr <= {d[3] ? 8'h56 : d[31:24], d[23:0]};
      @(posedge aclk);
    end
    // mid-run reset clears the written base
    s1 <= 32'hfff0_0ffa;
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rd(`WIN1_BASE_OFFSET, 34'h0_0000_000a);
    conclude;
  end
endmodule

// ===== testbench/window_regs_monitor.sv
/* assertions for the downstream window base registers
   sees only top-level ports; bound after the module */
`timescale 1ns/1ps
module window_regs_monitor (
  // clock and reset
  input wire aclk,
  input wire aresetn,
  // read data
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  // decode
  input wire [31:0] win1_setup,
  input wire [31:0] win2_setup,
  input wire [31:0] win1_xlat_base,
  input wire [31:0] win2_xlat_base,
  input wire [31:0] ds_addr,
  input wire win1_claim,
  input wire win2_claim,
  input wire [31:0] xlat_addr
);
  // ==========
  // properties
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_win1_needs_enable: assert property (
    win1_claim |-> $past(win1_setup[31])) else $error("win1 claim disabled");
  a_win2_nonzero_setup: assert property (
    win2_claim |-> $past(win2_setup) != 32'h0000_0000) else $error("win2 claim zero");
  a_miss_passes_addr: assert property (
    $past(aresetn) && !win1_claim && !win2_claim |-> xlat_addr == $past(ds_addr))
    else $error("miss changed address");
  a_win1_low_kept: assert property (
    win1_claim && !$past(win1_setup[0])
      |-> ((xlat_addr ^ $past(ds_addr)) & 32'h0000_0fff) == 32'h0000_0000)
    else $error("win1 low bits");
  a_win1_top_base: assert property (
    win1_claim |-> xlat_addr[31] == $past(win1_xlat_base[31])) else $error("win1 top");
  a_win2_top_base: assert property (
    win2_claim && !win1_claim |-> xlat_addr[31] == $past(win2_xlat_base[31]))
    else $error("win2 top");
  a_rsvd_read_zero: assert property (
    s_axi_rvalid |-> s_axi_rdata[11:4] == 8'h00) else $error("bits 11:4 set");
  a_type_no_high: assert property (
    s_axi_rvalid |-> !s_axi_rdata[2]) else $error("reserved type");
endmodule

bind downstream_window_base_regs window_regs_monitor u_window_regs_monitor (
  .aclk(aclk), .aresetn(aresetn), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .win1_setup(win1_setup), .win2_setup(win2_setup), .win1_xlat_base(win1_xlat_base),
  .win2_xlat_base(win2_xlat_base), .ds_addr(ds_addr), .win1_claim(win1_claim),
  .win2_claim(win2_claim), .xlat_addr(xlat_addr));
